// File: lgr_pkg.sv
// constants for the global receive configuration register bank
package lgr_pkg;
   localparam int          NUM_CHANNELS   = 14;
   localparam int          ATTEN_WIDTH    = 6;
   // register byte addresses
   localparam logic [7:0]  ADDR_MISC_CFG  = 8'he1;
   localparam logic [7:0]  ADDR_TERM_ATT  = 8'he2;
   localparam logic [7:0]  ADDR_SLICE_EQ  = 8'he3;
   localparam logic [7:0]  RESET_VALUE    = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
   // field positions in the misc register
   localparam int          POS_TEST_TRI   = 0;
   localparam int          POS_EXT_ZERO   = 1;
   localparam int          POS_SQUELCH    = 2;
   localparam int          POS_GAUGE_LO   = 4;
   localparam int          POS_GAUGE_HI   = 5;
   // field positions in the termination / attenuation register
   localparam int          POS_ATTEN_LO   = 0;
   localparam int          POS_ATTEN_HI   = 5;
   localparam int          POS_TERM_SRC   = 6;
   // field positions in the slicer / gain register
   localparam int          POS_EQG_LO     = 0;
   localparam int          POS_EQG_HI     = 1;
   localparam int          POS_SLICE_LO   = 2;
   localparam int          POS_SLICE_HI   = 3;
   // wire gauge encodings
   localparam logic [1:0]  GAUGE_MIXED    = 2'h0;
   localparam logic [1:0]  GAUGE_22       = 2'h1;
   localparam logic [1:0]  GAUGE_24       = 2'h2;
   localparam logic [1:0]  GAUGE_26       = 2'h3;
   // slicer threshold in percent of peak
   localparam logic [6:0]  SLICE_PCT_00   = 7'd50;
   localparam logic [6:0]  SLICE_PCT_01   = 7'd45;
   localparam logic [6:0]  SLICE_PCT_10   = 7'd55;
   localparam logic [6:0]  SLICE_PCT_11   = 7'd68;
   // equalizer gain reduction in dB
   localparam logic [1:0]  EQ_CUT_NORMAL  = 2'd0;
   localparam logic [1:0]  EQ_CUT_1DB     = 2'd1;
   localparam logic [1:0]  EQ_CUT_3DB     = 2'd3;
   // zero-run lengths, in received samples
   localparam int          ZERO_RUN_EXT   = 4096;
   localparam int          ZERO_RUN_NORM  = 175;
   localparam int          ZRUN_WIDTH     = 13;
endpackage

// File: lgr_channel.sv
// one receive channel: zero-run loss detect, output squelch, attenuation match
`timescale 1ns/10ps
module lgr_channel
   import lgr_pkg::*;
#(
   parameter int ZRUN_LIMIT_EXT  = ZERO_RUN_EXT,
   parameter int ZRUN_LIMIT_NORM = ZERO_RUN_NORM
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   rx_pos_in,
   input  wire logic                   rx_neg_in,
   input  wire logic                   rx_signal_loss,
   input  wire logic [ATTEN_WIDTH-1:0] cable_loss,
   input  wire logic                   atten_match_irq_en,
   input  wire logic                   rx_output_squelch_en,
   input  wire logic                   extended_zero_run_en,
   input  wire logic [ATTEN_WIDTH-1:0] atten_match_value,
   output logic                        rx_data_positive,
   output logic                        rx_data_negative,
   output logic                        digital_loss,
   output logic                        atten_match_irq
);
   logic [ZRUN_WIDTH-1:0] zero_run;
   logic [ZRUN_WIDTH-1:0] run_limit;

   // the limit tracks the mode bit live, so a change applies to the run in progress
   assign run_limit = extended_zero_run_en ? ZRUN_WIDTH'(ZRUN_LIMIT_EXT)
                                           : ZRUN_WIDTH'(ZRUN_LIMIT_NORM);

   // count consecutive zero samples, saturating at the limit
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         zero_run <= '0;
      end else if (rx_pos_in || rx_neg_in) begin
         zero_run <= '0;
      end else if (zero_run < run_limit) begin
         zero_run <= zero_run + ZRUN_WIDTH'(1);
      end
   end

   assign digital_loss = (zero_run >= run_limit);

   // received data is forced low while squelch is on and loss is present
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_data_positive <= 1'b0;
         rx_data_negative <= 1'b0;
      end else if (rx_output_squelch_en && rx_signal_loss) begin
         rx_data_positive <= 1'b0;
         rx_data_negative <= 1'b0;
      end else begin
         rx_data_positive <= rx_pos_in;
         rx_data_negative <= rx_neg_in;
      end
   end

   // level request while the cable loss equals the programmed value
   assign atten_match_irq = atten_match_irq_en && (cable_loss == atten_match_value);
endmodule

// File: lgr_global_rx_cfg.sv
// global receive configuration registers and their per-channel effects
`timescale 1ns/10ps

// Behaviour
// - gauge field encodes cable type
// - squelch forces receive data low on loss
// - extended mode needs 4096 zeros for loss
// - test bit clears pins_oe for the pad ring
// - termination source: register bit or pin
// - attenuation match raises channel interrupt
// - slicer field sets threshold percent
// - gain field reduces equalizer gain
// - interrupt output gated by global enable
module lgr_global_rx_cfg
   import lgr_pkg::*;
#(
   parameter int ZRUN_LIMIT_EXT  = ZERO_RUN_EXT,
   parameter int ZRUN_LIMIT_NORM = ZERO_RUN_NORM
) (
   input  wire logic                                sys_clk,
   input  wire logic                                rst,
   // microprocessor register port
   input  wire logic [7:0]                          cpu_addr,
   input  wire logic                                cpu_wr,
   input  wire logic                                cpu_rd,
   input  wire logic [7:0]                          cpu_wdata,
   output logic      [7:0]                          cpu_rdata,
   // neighbouring register bits and pins
   input  wire logic                                global_irq_en,
   input  wire logic [NUM_CHANNELS-1:0]             atten_match_irq_en,
   input  wire logic [NUM_CHANNELS-1:0]             rx_term_select_reg,
   input  wire logic                                rx_term_select_pin,
   input  wire logic [NUM_CHANNELS-1:0]             other_channel_irq,
   // receive path per channel
   input  wire logic [NUM_CHANNELS-1:0]             rx_signal_loss,
   input  wire logic [NUM_CHANNELS-1:0]             rx_pos_in,
   input  wire logic [NUM_CHANNELS-1:0]             rx_neg_in,
   input  wire logic [NUM_CHANNELS*ATTEN_WIDTH-1:0] cable_loss,
   output logic      [NUM_CHANNELS-1:0]             rx_data_positive,
   output logic      [NUM_CHANNELS-1:0]             rx_data_negative,
   output logic      [NUM_CHANNELS-1:0]             digital_loss,
   output logic      [NUM_CHANNELS-1:0]             rx_term_select,
   output logic      [NUM_CHANNELS-1:0]             channel_irq,
   output logic                                     irq,
   output logic                                     pins_oe,
   // analog control settings
   output logic      [1:0]                          wire_gauge_code,
   output logic      [6:0]                          slicer_pct,
   output logic      [1:0]                          eq_gain_cut_db
);
   logic [7:0]              misc_cfg;
   logic [7:0]              term_att;
   logic [7:0]              slice_eq;
   logic [NUM_CHANNELS-1:0] match_irq;
   logic [7:0]              next_rdata;
   logic [1:0]              slice_sel;
   logic [1:0]              eq_sel;
   logic [6:0]              next_slicer_pct;
   logic [1:0]              next_eq_cut;
   logic                    hit_misc;
   logic                    hit_term;
   logic                    hit_slice;
   logic                    wr_misc;
   logic                    wr_term;
   logic                    wr_slice;
   logic                    squelch_en;
   logic                    ext_zero_en;
   logic                    test_tristate;
   logic                    term_from_pin;
   logic [ATTEN_WIDTH-1:0]  atten_value;

   // address decode, shared by the write and the read path
   assign hit_misc  = (cpu_addr == ADDR_MISC_CFG);
   assign hit_term  = (cpu_addr == ADDR_TERM_ATT);
   assign hit_slice = (cpu_addr == ADDR_SLICE_EQ);

   // write strobes; a write to any other address is dropped without a trace
   assign wr_misc  = cpu_wr && hit_misc;
   assign wr_term  = cpu_wr && hit_term;
   assign wr_slice = cpu_wr && hit_slice;

   // misc register; reserved bits are kept as written so a readback never surprises
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         misc_cfg <= RESET_VALUE;
      end else if (wr_misc) begin
         misc_cfg <= cpu_wdata;
      end
   end

   // termination source and attenuation match register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         term_att <= RESET_VALUE;
      end else if (wr_term) begin
         term_att <= cpu_wdata;
      end
   end

   // slicer and gain register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slice_eq <= RESET_VALUE;
      end else if (wr_slice) begin
         slice_eq <= cpu_wdata;
      end
   end

   // read decode; unmapped addresses answer zero
   // a read and a write in one cycle return the old byte
   always_comb begin
      if (hit_misc) begin
         next_rdata = misc_cfg;
      end else if (hit_term) begin
         next_rdata = term_att;
      end else if (hit_slice) begin
         next_rdata = slice_eq;
      end else begin
         next_rdata = UNMAPPED_READ;
      end
   end

   // read data is held until the next read strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpu_rdata <= RESET_VALUE;
      end else if (cpu_rd) begin
         cpu_rdata <= next_rdata;
      end
   end

   // per-channel receive logic
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
         lgr_channel #(
            .ZRUN_LIMIT_EXT  (ZRUN_LIMIT_EXT),
            .ZRUN_LIMIT_NORM (ZRUN_LIMIT_NORM)
         ) u_chan (
            .sys_clk              (sys_clk),
            .rst                  (rst),
            .rx_pos_in            (rx_pos_in[ch]),
            .rx_neg_in            (rx_neg_in[ch]),
            .rx_signal_loss       (rx_signal_loss[ch]),
            .cable_loss           (cable_loss[ch*ATTEN_WIDTH +: ATTEN_WIDTH]),
            .atten_match_irq_en   (atten_match_irq_en[ch]),
            .rx_output_squelch_en (squelch_en),
            .extended_zero_run_en (ext_zero_en),
            .atten_match_value    (atten_value),
            .rx_data_positive     (rx_data_positive[ch]),
            .rx_data_negative     (rx_data_negative[ch]),
            .digital_loss         (digital_loss[ch]),
            .atten_match_irq      (match_irq[ch])
         );
      end
   endgenerate

   // field taps, named once so the channel wiring reads plainly
   // the channels see the live register bits, so a mode change acts at once
   assign squelch_en    = misc_cfg[POS_SQUELCH];
   assign ext_zero_en   = misc_cfg[POS_EXT_ZERO];
   assign test_tristate = misc_cfg[POS_TEST_TRI];
   assign term_from_pin = term_att[POS_TERM_SRC];
   assign atten_value   = term_att[POS_ATTEN_HI:POS_ATTEN_LO];

   // termination select: per-channel register bit or the shared pin
   assign rx_term_select = term_from_pin ? {NUM_CHANNELS{rx_term_select_pin}}
                                         : rx_term_select_reg;

   // channel requests reach the pin only with the global enable set
   assign channel_irq = match_irq | other_channel_irq;
   assign irq         = global_irq_en && (|channel_irq);

   // board test mode releases every output pin; the pad ring uses this enable
   // limitation: only the enable is made here, the pads themselves sit outside
   assign pins_oe = ~test_tristate;

   // cable type straight from the gauge field
   assign wire_gauge_code = misc_cfg[POS_GAUGE_HI:POS_GAUGE_LO];

   // the analog settings are decoded from the write data, so they come out of
   // flip-flops in the same cycle as the register byte itself
   assign slice_sel = cpu_wdata[POS_SLICE_HI:POS_SLICE_LO];
   assign eq_sel    = cpu_wdata[POS_EQG_HI:POS_EQG_LO];

   // slicer threshold decode
   always_comb begin
      case (slice_sel)
         2'h0:    next_slicer_pct = SLICE_PCT_00;
         2'h1:    next_slicer_pct = SLICE_PCT_01;
         2'h2:    next_slicer_pct = SLICE_PCT_10;
         default: next_slicer_pct = SLICE_PCT_11;
      endcase
   end

   // both end codes mean normal gain
   always_comb begin
      case (eq_sel)
         2'h0:    next_eq_cut = EQ_CUT_NORMAL;
         2'h1:    next_eq_cut = EQ_CUT_1DB;
         2'h2:    next_eq_cut = EQ_CUT_3DB;
         default: next_eq_cut = EQ_CUT_NORMAL;
      endcase
   end

   // slicer threshold register, loaded together with its register byte
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slicer_pct <= SLICE_PCT_00;
      end else if (wr_slice) begin
         slicer_pct <= next_slicer_pct;
      end
   end

   // gain reduction register, loaded together with its register byte
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         eq_gain_cut_db <= EQ_CUT_NORMAL;
      end else if (wr_slice) begin
         eq_gain_cut_db <= next_eq_cut;
      end
   end
endmodule

// File: lgr_global_rx_cfg_props.sv
// checker for the global receive configuration register bank
`timescale 1ns/10ps
module lgr_global_rx_cfg_props
   import lgr_pkg::*;
(
   input wire logic                    sys_clk,
   input wire logic                    rst,
   input wire logic [7:0]              cpu_addr,
   input wire logic                    cpu_wr,
   input wire logic                    cpu_rd,
   input wire logic [7:0]              cpu_wdata,
   input wire logic [7:0]              cpu_rdata,
   input wire logic                    global_irq_en,
   input wire logic [NUM_CHANNELS-1:0] channel_irq,
   input wire logic                    irq,
   input wire logic                    pins_oe,
   input wire logic [1:0]              wire_gauge_code,
   input wire logic [6:0]              slicer_pct,
   input wire logic [1:0]              eq_gain_cut_db
);
   // expected analog settings, indexed by field value
   logic [6:0] pct [4] = '{7'h32, 7'h2d, 7'h37, 7'h44};
   logic [1:0] cut [4] = '{2'h0, 2'h1, 2'h3, 2'h0};
   logic [7:0] wd_q;
   // last write data, so the settings can be tied to it one cycle on
   always_ff @(posedge sys_clk) begin
      wd_q <= cpu_wdata;
   end
   // one clock domain, so clock and reset are stated once
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // steps of a register access
   sequence s_wr(logic [7:0] a); cpu_wr && cpu_addr == a; endsequence
   sequence s_rd(logic [7:0] a); cpu_rd && !cpu_wr && cpu_addr == a; endsequence
   property p_gauge; s_wr(ADDR_MISC_CFG) |=>
      wire_gauge_code == $past(cpu_wdata[5:4]); endproperty
   a_gauge: assert property (p_gauge) else $error("gauge code wrong");
   property p_oe; s_wr(ADDR_MISC_CFG) |=> pins_oe == !$past(cpu_wdata[0]); endproperty
   a_oe: assert property (p_oe) else $error("output enable wrong");
   property p_slice; s_wr(ADDR_SLICE_EQ) |=> slicer_pct == pct[wd_q[3:2]]; endproperty
   a_slice: assert property (p_slice) else $error("slicer level wrong");
   property p_eq; s_wr(ADDR_SLICE_EQ) |=> eq_gain_cut_db == cut[wd_q[1:0]]; endproperty
   a_eq: assert property (p_eq) else $error("gain cut wrong");
   property p_irq; irq == (global_irq_en && (|channel_irq)); endproperty
   a_irq: assert property (p_irq) else $error("irq gating wrong");
   property p_rdbk; s_wr(ADDR_TERM_ATT) ##1 s_rd(ADDR_TERM_ATT) |=>
      cpu_rdata == $past(cpu_wdata, 2); endproperty
   a_rdbk: assert property (p_rdbk) else $error("readback wrong");
   property p_unmap; s_rd(8'he0) |=> cpu_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
   // reset itself is the cause here, so the default disable is lifted
   property p_rst; disable iff (1'h0) rst |=> cpu_rdata == 8'h00 && pins_oe; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

bind lgr_global_rx_cfg lgr_global_rx_cfg_props u_props (
   .sys_clk         (sys_clk),
   .rst             (rst),
   .cpu_addr        (cpu_addr),
   .cpu_wr          (cpu_wr),
   .cpu_rd          (cpu_rd),
   .cpu_wdata       (cpu_wdata),
   .cpu_rdata       (cpu_rdata),
   .global_irq_en   (global_irq_en),
   .channel_irq     (channel_irq),
   .irq             (irq),
   .pins_oe         (pins_oe),
   .wire_gauge_code (wire_gauge_code),
   .slicer_pct      (slicer_pct),
   .eq_gain_cut_db  (eq_gain_cut_db)
);

// File: test_lgr_global_rx_cfg.sv
// self-checking bench for the global receive configuration register bank
`timescale 1ns/10ps
module test_lgr_global_rx_cfg;
   import lgr_pkg::*;
   localparam int N = NUM_CHANNELS;
   logic         sys_clk = 1'h0, rst = 1'h1, cpu_wr = 1'h0, cpu_rd = 1'h0, irq, pins_oe;
   logic         global_irq_en = 1'h0, rx_term_select_pin = 1'h0;
   logic [7:0]   cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata;
   logic [N-1:0] atten_match_irq_en = '0, rx_term_select_reg = '0, other_channel_irq = '0;
   logic [N-1:0] rx_signal_loss = '0, rx_pos_in = 14'h2aaa, rx_neg_in = 14'h1555;
   logic [N-1:0] rx_data_positive, rx_data_negative, digital_loss, rx_term_select, channel_irq;
   logic [N*ATTEN_WIDTH-1:0] cable_loss = '0;
   logic [1:0]   wire_gauge_code, eq_gain_cut_db;
   logic [6:0]   slicer_pct, pct [4] = '{7'h32, 7'h2d, 7'h37, 7'h44};
   logic [1:0]   cut [4] = '{2'h0, 2'h1, 2'h3, 2'h0};
   int           fail_count = 0, check_count = 0;
   // short zero-run limits keep the loss test brief
   lgr_global_rx_cfg #(.ZRUN_LIMIT_EXT(40), .ZRUN_LIMIT_NORM(8)) DUT (
      .sys_clk            (sys_clk),
      .rst                (rst),
      .cpu_addr           (cpu_addr),
      .cpu_wr             (cpu_wr),
      .cpu_rd             (cpu_rd),
      .cpu_wdata          (cpu_wdata),
      .cpu_rdata          (cpu_rdata),
      .global_irq_en      (global_irq_en),
      .atten_match_irq_en (atten_match_irq_en),
      .rx_term_select_reg (rx_term_select_reg),
      .rx_term_select_pin (rx_term_select_pin),
      .other_channel_irq  (other_channel_irq),
      .rx_signal_loss     (rx_signal_loss),
      .rx_pos_in          (rx_pos_in),
      .rx_neg_in          (rx_neg_in),
      .cable_loss         (cable_loss),
      .rx_data_positive   (rx_data_positive),
      .rx_data_negative   (rx_data_negative),
      .digital_loss       (digital_loss),
      .rx_term_select     (rx_term_select),
      .channel_irq        (channel_irq),
      .irq                (irq),
      .pins_oe            (pins_oe),
      .wire_gauge_code    (wire_gauge_code),
      .slicer_pct         (slicer_pct),
      .eq_gain_cut_db     (eq_gain_cut_db)
   );
   // free-running system clock
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // every drive lands one time unit after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      cpu_addr = a;
      cpu_rd = 1'h1;
      tick(1);
      cpu_rd = 1'h0;
      chk({6'h00, cpu_rdata}, {6'h00, e});
      tick(1);
   endtask
   // the read straight after a write also checks that the byte was kept
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'h1;
      tick(1);
      cpu_wr = 1'h0;
      rd(a, e);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // the tests need well under a thousand cycles
   initial begin
      #100000;
      fail_count++;
      results();
   end
   // main sequence
   initial begin
      tick(20);
      rst = 1'h0;
      rd(ADDR_MISC_CFG, 8'h00);
      rd(ADDR_TERM_ATT, 8'h00);
      rd(ADDR_SLICE_EQ, 8'h00);
      $display("reset values done");
      for (int g = 0; g < 4; g++) begin
         wr(ADDR_MISC_CFG, {2'h0, g[1:0], 4'h0}, {2'h0, g[1:0], 4'h0});
         chk(wire_gauge_code, g[1:0]);
      end
      wr(ADDR_MISC_CFG, 8'h01, 8'h01);
      chk(pins_oe, 1'h0);
      wr(ADDR_MISC_CFG, 8'h00, 8'h00);
      chk(pins_oe, 1'h1);
      $display("gauge and test tristate done");
      rx_signal_loss = 14'h00ff;
      wr(ADDR_MISC_CFG, 8'h04, 8'h04);
      chk(rx_data_positive, 14'h2a00);
      chk(rx_data_negative, 14'h1500);
      rx_signal_loss = '0;
      tick(2);
      chk(rx_data_positive, 14'h2aaa);
      $display("squelch done");
      rx_pos_in = '0;
      rx_neg_in = '0;
      tick(12);
      chk(digital_loss, 14'h3fff);
      wr(ADDR_MISC_CFG, 8'h02, 8'h02);
      chk(digital_loss, 14'h0000);
      tick(30);
      chk(digital_loss, 14'h3fff);
      rx_pos_in = 14'h2aaa;
      rx_neg_in = 14'h1555;
      tick(2);
      chk(digital_loss, 14'h0000);
      $display("zero run done");
      rx_term_select_reg = 14'h0f0f;
      rx_term_select_pin = 1'h1;
      wr(ADDR_TERM_ATT, 8'h40, 8'h40);
      chk(rx_term_select, 14'h3fff);
      wr(ADDR_TERM_ATT, 8'h3f, 8'h3f);
      chk(rx_term_select, 14'h0f0f);
      cable_loss[3*ATTEN_WIDTH +: ATTEN_WIDTH] = 6'h3f;
      atten_match_irq_en = 14'h0018;
      tick(1);
      chk(channel_irq, 14'h0008);
      chk(irq, 1'h0);
      global_irq_en = 1'h1;
      tick(1);
      chk(irq, 1'h1);
      atten_match_irq_en = '0;
      other_channel_irq = 14'h2000;
      tick(1);
      chk(channel_irq, 14'h2000);
      chk(irq, 1'h1);
      $display("termination and interrupt done");
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_SLICE_EQ, {4'h0, i[1:0], i[1:0]}, {4'h0, i[1:0], i[1:0]});
         chk(slicer_pct, pct[i]);
         chk(eq_gain_cut_db, cut[i]);
      end
      wr(8'he0, 8'h5a, 8'h00);
      rd(ADDR_SLICE_EQ, 8'h0f);
      $display("slicer, gain and unmapped done");
      results();
   end
endmodule
